// *** design/jlc_pkg.sv ***
package jlc_pkg;
	// Register bus
	localparam int ADR_W = 12;
	localparam logic [11:0] OFS_LINK_CTRL = 12'h574;
	localparam logic [11:0] OFS_LMFC_PHASE = 12'h578;
	localparam logic [11:0] OFS_DEV_ID = 12'h580;
	localparam logic [11:0] OFS_STATUS = 12'h5a0;

	// Field layout
	localparam int DLY_LSB = 4;
	localparam int DLY_W = 4;
	localparam int TM_LSB = 0;
	localparam int TM_W = 3;
	localparam int OFS_W = 5;
	localparam int DID_W = 8;
	localparam int STS_SYNC_BIT = 4;

	// Reset values
	localparam logic [3:0] RST_DLY = 4'h0;
	localparam logic [2:0] RST_TM = 3'h0;
	localparam logic [4:0] RST_OFS = 5'h00;
	localparam logic [7:0] RST_DID = 8'h00;

	// Link layer test codes
	localparam logic [2:0] TM_NORMAL = 3'h0;
	localparam logic [2:0] TM_D215 = 3'h1;
	localparam logic [2:0] TM_RPAT = 3'h4;
	localparam logic [2:0] TM_JSPAT = 3'h5;
	localparam logic [2:0] TM_JTSPAT = 3'h6;

	// Characters
	localparam logic [7:0] CH_K285 = 8'hbc;
	localparam logic [7:0] CH_K280 = 8'h1c;
	localparam logic [7:0] CH_K283 = 8'h7c;
	localparam logic [7:0] CH_K284 = 8'h9c;
	localparam logic [7:0] CH_D215 = 8'hb5;
	localparam logic [7:0] CH_IDLE = 8'h00;

	// ILAS layout
	localparam int ILAS_MF = 4;
	localparam logic [4:0] ILAS_POS_Q = 5'h01;
	localparam logic [4:0] ILAS_POS_DID = 5'h02;
	localparam logic [1:0] ILAS_CFG_MF = 2'h1;

	// Test pattern tables, entry 0 in the low byte
	localparam int PAT_LEN = 12;
	localparam int PAT_W = 4;
	localparam logic [95:0] TBL_RPAT = 96'h0e87c3e170381c8e47a3d7be;
	localparam logic [95:0] TBL_JSPAT = 96'h6b1ca5f03d87e2591b4c7e7e;
	localparam logic [95:0] TBL_JTSPAT = 96'h95e3a10fc2781da6e4b38181;

	typedef enum logic [3:0] {
		ST_CGS = 4'h1,
		ST_WAIT = 4'h2,
		ST_ILAS = 4'h4,
		ST_DATA = 4'h8
	} jlc_state_type;

	function automatic logic [7:0] jlc_pattern(input logic [2:0] code, input logic [PAT_W-1:0] idx);
		logic [95:0] tbl;
		tbl = TBL_RPAT;
		if (code == TM_JSPAT) begin
			tbl = TBL_JSPAT;
		end else if (code == TM_JTSPAT) begin
			tbl = TBL_JTSPAT;
		end
		return tbl[idx*8 +: 8];
	endfunction
endpackage

// *** design/jlc_stream_if.sv ***
`timescale 1ns/10ps
interface jlc_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

// *** design/jlc_fifo.sv ***
`timescale 1ns/10ps
module jlc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	jlc_stream_if.snk in_s,
	jlc_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("jlc_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_s.ready = (cnt_q != DEPTH[AW:0]);
	assign out_s.valid = (cnt_q != '0);
	assign out_s.data = mem_q[rd_q];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_s.data;
			wr_d = wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		mem_q <= mem_d;
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // jlc_fifo

// *** design/jlc_link_ctrl.sv ***
// Function
// [RULE1] ILAS starts on LMFC boundary delay plus one
// [RULE2] Test code zero passes normal link traffic
// [RULE3] Code 001 sends continuous D21.5 characters
// [RULE4] Code 100 sends modified RPAT sequence
// [RULE5] LMFC phase shifted by offset frame clocks
// [RULE6] Writable device identifier, reset zero, reported
// [RULE7] Codes 101/110 JSPAT/JTSPAT; others reserved
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
module jlc_link_ctrl #(
	parameter int MF_FRAMES = 32,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic sync_request_n_i,
	input wire logic frame_tick_i,
	input wire logic [7:0] src_data_i,
	input wire logic src_valid_i,
	output logic src_ready_o,
	output logic [7:0] lane_char_o,
	output logic lane_k_o,
	output logic lane_valid_o,
	output logic lmfc_o,
	output logic ilas_active_o,
	output logic [7:0] did_o
);
	if (MF_FRAMES != (1 << jlc_pkg::OFS_W)) begin : g_bad_frames
		$error("jlc_link_ctrl: MF_FRAMES must match the offset field range");
	end

	localparam logic [4:0] POS_LAST = 5'(MF_FRAMES - 1);
	localparam logic [1:0] ILAS_LAST = 2'(jlc_pkg::ILAS_MF - 1);
	localparam logic [3:0] PAT_LAST = 4'(jlc_pkg::PAT_LEN - 1);

	////////////////////////////////////////////////////////////////
	// Sample FIFO
	jlc_stream_if #(.WIDTH(8)) fin_if ();
	jlc_stream_if #(.WIDTH(8)) fout_if ();
	logic pop;

	assign fin_if.data = src_data_i;
	assign fin_if.valid = src_valid_i;
	assign src_ready_o = fin_if.ready;
	assign fout_if.ready = pop;

	jlc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_s(fin_if),
		.out_s(fout_if)
	);

	////////////////////////////////////////////////////////////////
	// Sync request synchroniser, low means request
	logic sync_s1_q, sync_s2_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_s1_q <= 1'b0;
			sync_s2_q <= 1'b0;
		end else begin
			sync_s1_q <= sync_request_n_i;
			sync_s2_q <= sync_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Wishbone register file
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [3:0] dly_q, dly_d;
	logic [2:0] tm_q, tm_d;
	logic [4:0] ofs_q, ofs_d;
	logic [7:0] did_q, did_d;
	logic wr_en;
	jlc_pkg::jlc_state_type st_q, st_d;

	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

	always_comb begin
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		rdat_d = '0;
		dly_d = dly_q;
		tm_d = tm_q;
		ofs_d = ofs_q;
		did_d = did_q;
		case (wb_adr_i)
			jlc_pkg::OFS_LINK_CTRL: begin
				rdat_d[jlc_pkg::DLY_LSB +: jlc_pkg::DLY_W] = dly_q;
				rdat_d[jlc_pkg::TM_LSB +: jlc_pkg::TM_W] = tm_q;
				if (wr_en) begin
					dly_d = wb_dat_i[jlc_pkg::DLY_LSB +: jlc_pkg::DLY_W];
					tm_d = wb_dat_i[jlc_pkg::TM_LSB +: jlc_pkg::TM_W];
				end
			end
			jlc_pkg::OFS_LMFC_PHASE: begin
				rdat_d[jlc_pkg::OFS_W-1:0] = ofs_q;
				if (wr_en) begin
					ofs_d = wb_dat_i[jlc_pkg::OFS_W-1:0];
				end
			end
			jlc_pkg::OFS_DEV_ID: begin
				rdat_d[jlc_pkg::DID_W-1:0] = did_q;
				if (wr_en) begin
					did_d = wb_dat_i[jlc_pkg::DID_W-1:0]; // RULE6
				end
			end
			jlc_pkg::OFS_STATUS: begin
				rdat_d[3:0] = st_q;
				rdat_d[jlc_pkg::STS_SYNC_BIT] = sync_s2_q;
			end
			default: begin
				rdat_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= '0;
			dly_q <= jlc_pkg::RST_DLY;
			tm_q <= jlc_pkg::RST_TM;
			ofs_q <= jlc_pkg::RST_OFS;
			did_q <= jlc_pkg::RST_DID;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			dly_q <= dly_d;
			tm_q <= tm_d;
			ofs_q <= ofs_d;
			did_q <= did_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign did_o = did_q; // RULE6

	////////////////////////////////////////////////////////////////
	// Link sequencing and lane character generation
	logic [4:0] lmfc_cnt_q, lmfc_cnt_d, pos;
	logic [3:0] bcnt_q, bcnt_d;
	logic [1:0] mfc_q, mfc_d, ilas_mf;
	logic [3:0] pat_q, pat_d;
	logic [7:0] char_q, char_d;
	logic k_q, k_d, lvalid_q, lvalid_d, lmfc_q, lmfc_d;
	logic boundary, test_on;

	assign pos = lmfc_cnt_q - ofs_q; // RULE5
	assign boundary = (pos == '0);
	assign ilas_mf = (st_q == jlc_pkg::ST_ILAS) ? mfc_q : '0;
	assign test_on = (tm_q == jlc_pkg::TM_D215) || (tm_q == jlc_pkg::TM_RPAT) ||
		(tm_q == jlc_pkg::TM_JSPAT) || (tm_q == jlc_pkg::TM_JTSPAT); // RULE7

	always_comb begin
		st_d = st_q;
		bcnt_d = bcnt_q;
		mfc_d = mfc_q;
		lmfc_cnt_d = lmfc_cnt_q;
		pat_d = pat_q;
		char_d = char_q;
		k_d = k_q;
		lvalid_d = 1'b0;
		lmfc_d = 1'b0;
		pop = 1'b0;
		if (!sync_s2_q) begin
			st_d = jlc_pkg::ST_CGS;
			bcnt_d = '0;
		end else begin
			case (st_q)
				jlc_pkg::ST_CGS: begin
					st_d = jlc_pkg::ST_WAIT;
					bcnt_d = '0;
				end
				jlc_pkg::ST_WAIT: begin
					if (frame_tick_i && boundary) begin
						if (bcnt_q == dly_q) begin
							st_d = jlc_pkg::ST_ILAS; // RULE1
							mfc_d = '0;
						end else begin
							bcnt_d = bcnt_q + 1'b1; // RULE1
						end
					end
				end
				jlc_pkg::ST_ILAS: begin
					if (frame_tick_i && pos == POS_LAST) begin
						if (mfc_q == ILAS_LAST) begin
							st_d = jlc_pkg::ST_DATA;
						end else begin
							mfc_d = mfc_q + 1'b1;
						end
					end
				end
				jlc_pkg::ST_DATA: begin
					st_d = jlc_pkg::ST_DATA;
				end
				default: begin
					st_d = jlc_pkg::ST_CGS;
				end
			endcase
		end
		if (frame_tick_i) begin
			lmfc_cnt_d = lmfc_cnt_q + 1'b1;
			lmfc_d = boundary; // RULE5
			lvalid_d = 1'b1;
			pat_d = (pat_q == PAT_LAST) ? '0 : pat_q + 1'b1;
			k_d = 1'b0;
			if (tm_q == jlc_pkg::TM_D215) begin
				char_d = jlc_pkg::CH_D215; // RULE3
			end else if (test_on) begin
				char_d = jlc_pkg::jlc_pattern(tm_q, pat_q); // RULE4 RULE7
			end else if (!sync_s2_q) begin
				char_d = jlc_pkg::CH_K285;
				k_d = 1'b1;
			end else if (st_q == jlc_pkg::ST_ILAS || st_d == jlc_pkg::ST_ILAS) begin
				if (pos == '0) begin
					char_d = jlc_pkg::CH_K280; // RULE1
					k_d = 1'b1;
				end else if (pos == POS_LAST) begin
					char_d = jlc_pkg::CH_K283;
					k_d = 1'b1;
				end else if (ilas_mf == jlc_pkg::ILAS_CFG_MF && pos == jlc_pkg::ILAS_POS_Q) begin
					char_d = jlc_pkg::CH_K284;
					k_d = 1'b1;
				end else if (ilas_mf == jlc_pkg::ILAS_CFG_MF && pos == jlc_pkg::ILAS_POS_DID) begin
					char_d = did_q; // RULE6
				end else begin
					char_d = {3'h0, pos};
				end
			end else if (st_q == jlc_pkg::ST_DATA) begin
				pop = fout_if.valid; // RULE2
				char_d = fout_if.valid ? fout_if.data : jlc_pkg::CH_IDLE; // RULE2
			end else begin
				char_d = jlc_pkg::CH_K285;
				k_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= jlc_pkg::ST_CGS;
			bcnt_q <= '0;
			mfc_q <= '0;
			lmfc_cnt_q <= '0;
			pat_q <= '0;
			char_q <= '0;
			k_q <= 1'b0;
			lvalid_q <= 1'b0;
			lmfc_q <= 1'b0;
		end else begin
			st_q <= st_d;
			bcnt_q <= bcnt_d;
			mfc_q <= mfc_d;
			lmfc_cnt_q <= lmfc_cnt_d;
			pat_q <= pat_d;
			char_q <= char_d;
			k_q <= k_d;
			lvalid_q <= lvalid_d;
			lmfc_q <= lmfc_d;
		end
	end

	assign lane_char_o = char_q;
	assign lane_k_o = k_q;
	assign lane_valid_o = lvalid_q;
	assign lmfc_o = lmfc_q;
	assign ilas_active_o = (st_q == jlc_pkg::ST_ILAS);

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_ilas_entry;
		sync_s2_q && st_q == jlc_pkg::ST_WAIT && frame_tick_i && boundary && bcnt_q == dly_q;
	endsequence

	sequence s_early_boundary;
		sync_s2_q && st_q == jlc_pkg::ST_WAIT && frame_tick_i && boundary && bcnt_q != dly_q;
	endsequence

	sequence s_dev_id_write;
		wr_en && wb_adr_i == jlc_pkg::OFS_DEV_ID;
	endsequence

	ilas_start_a: assert property (s_ilas_entry ##0 !test_on |=> // RULE1
		ilas_active_o && lane_k_o && lane_char_o == jlc_pkg::CH_K280)
		else $error("ILAS did not start on the selected boundary");

	ilas_hold_a: assert property (s_early_boundary |=> // RULE1
		st_q == jlc_pkg::ST_WAIT && bcnt_q == $past(bcnt_q) + 4'h1)
		else $error("ILAS started before the selected boundary");

	normal_data_a: assert property (tm_q == jlc_pkg::TM_NORMAL && frame_tick_i && sync_s2_q && // RULE2
		st_q == jlc_pkg::ST_DATA && fout_if.valid |=> !lane_k_o && lane_char_o == $past(fout_if.data))
		else $error("Normal traffic not passed to the lane");

	d215_a: assert property (tm_q == jlc_pkg::TM_D215 && frame_tick_i |=> // RULE3
		lane_valid_o && !lane_k_o && lane_char_o == jlc_pkg::CH_D215)
		else $error("D21.5 test stream broken");

	rpat_seq_a: assert property (tm_q == jlc_pkg::TM_RPAT && frame_tick_i |=> // RULE4
		lane_char_o == jlc_pkg::jlc_pattern(jlc_pkg::TM_RPAT, $past(pat_q)) && !lane_k_o)
		else $error("RPAT test sequence wrong");

	lmfc_phase_a: assert property (frame_tick_i && lmfc_cnt_q == ofs_q |=> lmfc_o) // RULE5
		else $error("LMFC edge not at programmed phase");

	lmfc_only_a: assert property (frame_tick_i && lmfc_cnt_q != ofs_q |=> !lmfc_o) // RULE5
		else $error("LMFC edge at wrong phase");

	dev_id_a: assert property (s_dev_id_write |=> did_o == $past(wb_dat_i[7:0])) // RULE6
		else $error("Device identifier not updated by write");

	scr_pat_a: assert property ((tm_q == jlc_pkg::TM_JSPAT || tm_q == jlc_pkg::TM_JTSPAT) && // RULE7
		frame_tick_i |=> lane_char_o == jlc_pkg::jlc_pattern($past(tm_q), $past(pat_q)))
		else $error("Scrambled test sequence wrong");

	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus acknowledge not a single cycle");

	sync_hold_a: assert property (!sync_s2_q |=> !ilas_active_o) // RULE1
		else $error("ILAS sent while sync requested");

	ilas_did_a: assert property (st_q == jlc_pkg::ST_ILAS && sync_s2_q && tm_q == jlc_pkg::TM_NORMAL && // RULE6
		frame_tick_i && mfc_q == jlc_pkg::ILAS_CFG_MF && pos == jlc_pkg::ILAS_POS_DID |=>
		lane_char_o == $past(did_q) && !lane_k_o)
		else $error("Device identifier missing from ILAS");

	data_idle_a: assert property (st_q == jlc_pkg::ST_DATA && sync_s2_q && tm_q == jlc_pkg::TM_NORMAL && // RULE2
		frame_tick_i && !fout_if.valid |=> !lane_k_o && lane_char_o == jlc_pkg::CH_IDLE)
		else $error("Idle character not sent on empty buffer");

	fifo_hold_a: assert property (st_q != jlc_pkg::ST_DATA |-> !pop) // RULE2
		else $error("Sample buffer drained outside data phase");
endmodule // jlc_link_ctrl

// *** sim/jlc_rx_model.sv ***
`timescale 1ns/10ps
module jlc_rx_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [7:0] char_i,
	input wire logic k_i,
	input wire logic valid_i,
	output logic sync_request_n_o
);
	logic [2:0] cgs_q;
	////////////////////////////////////////
	// Sync stays low until four commas are seen
	always_ff @(posedge clk_i) begin
		if (rst_i || req_i) begin
			cgs_q <= 3'h0;
		end else if (valid_i && k_i && char_i == jlc_pkg::CH_K285 && cgs_q != 3'h4) begin
			cgs_q <= cgs_q + 3'h1;
		end
	end
	assign sync_request_n_o = (cgs_q == 3'h4);
endmodule // jlc_rx_model

// *** sim/jlc_link_ctrl_test.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module jlc_link_ctrl_test;
	logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, frame_tick_i, src_valid_i, src_ready_o;
	logic lane_k_o, lane_valid_o, lmfc_o, ilas_active_o, sync_n, tick_en, req;
	logic [11:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i;
	logic [7:0] src_data_i, lane_char_o, did_o;
	int num_errors, num_checks, ticks;
	jlc_link_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sync_request_n_i(sync_n), .frame_tick_i(frame_tick_i),
		.src_data_i(src_data_i), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
		.lane_char_o(lane_char_o), .lane_k_o(lane_k_o), .lane_valid_o(lane_valid_o), .lmfc_o(lmfc_o),
		.ilas_active_o(ilas_active_o), .did_o(did_o));
	jlc_rx_model rx (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .char_i(lane_char_o), .k_i(lane_k_o),
		.valid_i(lane_valid_o), .sync_request_n_o(sync_n));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		frame_tick_i <= tick_en & ~frame_tick_i;
		ticks <= rst_i ? 0 : ticks + int'(frame_tick_i);
	end
	////////////////////////////////////////
	task wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e, input string n);
		wb(1'b0, a, 32'h0, 4'hf);
		`CHK(n, e, rd)
	endtask
	task wait_valid();
		int t;
		t = 0;
		do begin @(posedge clk_i); t++; end while (lane_valid_o !== 1'b1 && t < 100);
		`CHK("lane valid", 1'b1, lane_valid_o)
	endtask
	task wait_lmfc();
		int t;
		t = 0;
		do begin @(posedge clk_i); t++; end while (lmfc_o !== 1'b1 && t < 100);
		`CHK("lmfc seen", 1'b1, lmfc_o)
	endtask
	////////////////////////////////////////
	task t_regs();
		rchk(jlc_pkg::OFS_LINK_CTRL, 32'h0, "ctrl reset");
		rchk(jlc_pkg::OFS_LMFC_PHASE, 32'h0, "phase reset");
		rchk(jlc_pkg::OFS_DEV_ID, 32'h0, "id reset");
		rchk(jlc_pkg::OFS_STATUS, 32'h1, "status reset");
		wb(1'b1, jlc_pkg::OFS_LINK_CTRL, 32'hff, 4'hf);
		rchk(jlc_pkg::OFS_LINK_CTRL, 32'hf7, "ctrl rw");
		wb(1'b1, jlc_pkg::OFS_LMFC_PHASE, 32'hff, 4'hf);
		rchk(jlc_pkg::OFS_LMFC_PHASE, 32'h1f, "phase rw");
		wb(1'b1, jlc_pkg::OFS_DEV_ID, 32'h5a, 4'hf);
		wb(1'b1, jlc_pkg::OFS_DEV_ID, 32'hc3, 4'he);
		rchk(jlc_pkg::OFS_DEV_ID, 32'h5a, "id rw");
		`CHK("id port", 8'h5a, did_o)
		wb(1'b1, 12'h590, 32'hff, 4'hf);
		rchk(12'h590, 32'h0, "unmapped");
		wb(1'b1, jlc_pkg::OFS_LINK_CTRL, 32'h0, 4'hf);
		wb(1'b1, jlc_pkg::OFS_LMFC_PHASE, 32'h0, 4'hf);
		$display("test regs done");
	endtask
	task t_modes();
		logic [95:0] tbl;
		logic [7:0] e;
		logic ek;
		for (int c = 0; c < 8; c++) begin
			wb(1'b1, jlc_pkg::OFS_LINK_CTRL, 32'(c), 4'hf);
			repeat (4) @(posedge clk_i);
			repeat (2) begin
				wait_valid();
				tbl = c == 4 ? jlc_pkg::TBL_RPAT : c == 5 ? jlc_pkg::TBL_JSPAT : jlc_pkg::TBL_JTSPAT;
				e = tbl[((ticks - 1) % 12) * 8 +: 8];
				ek = 1'b0;
				if (c == 1) begin
					e = jlc_pkg::CH_D215;
				end else if (c != 4 && c != 5 && c != 6) begin
					e = jlc_pkg::CH_K285;
					ek = 1'b1;
				end
				`CHK("mode char", e, lane_char_o)
				`CHK("mode k", ek, lane_k_o)
			end
		end
		wb(1'b1, jlc_pkg::OFS_LINK_CTRL, 32'h0, 4'hf);
		$display("test modes done");
	endtask
	task t_phase(input logic [4:0] o);
		wb(1'b1, jlc_pkg::OFS_LMFC_PHASE, {27'h0, o}, 4'hf);
		repeat (4) @(posedge clk_i);
		wait_lmfc();
		`CHK("lmfc phase", 5'h0, 5'(ticks - 1 - int'(o)))
		$display("test phase done");
	endtask
	task t_ilas(input logic [3:0] d);
		int acc, n;
		wb(1'b1, jlc_pkg::OFS_LINK_CTRL, {24'h0, d, 4'h0}, 4'hf);
		src_valid_i <= 1'b1;
		src_data_i <= 8'ha0;
		acc = 0;
		repeat (12) begin
			@(posedge clk_i);
			if (src_ready_o === 1'b1) begin
				acc++;
				src_data_i <= 8'ha0 + 8'(acc);
			end
		end
		src_valid_i <= 1'b0;
		`CHK("fifo fill", 8, acc)
		wait_lmfc();
		req <= 1'b0;
		n = 0;
		do begin wait_lmfc(); n++; end while (ilas_active_o !== 1'b1 && n < 20);
		`CHK("ilas boundary", int'(d) + 1, n)
		n = 0;
		acc = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (lane_valid_o === 1'b1 && acc == 1) begin
				`CHK("ilas id", 8'h5a, lane_char_o)
				acc = 2;
			end else if (lane_valid_o === 1'b1 && lane_k_o === 1'b1 && lane_char_o === jlc_pkg::CH_K284) begin
				acc = 1;
			end
		end while (ilas_active_o !== 1'b0 && n < 400);
		`CHK("ilas end", 1'b0, ilas_active_o)
		`CHK("ilas id seen", 2, acc)
		for (int i = 0; i < 9; i++) begin
			wait_valid();
			`CHK("lane data", i < 8 ? 8'ha0 + 8'(i) : 8'h00, lane_char_o)
			`CHK("lane data k", 1'b0, lane_k_o)
		end
		req <= 1'b1;
		$display("test ilas done");
	endtask
	////////////////////////////////////////
	task stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		stop_test();
	end
	initial begin
		{rst_i, req} = 2'b11;
		{wb_we_i, wb_cyc_i, wb_stb_i, frame_tick_i, src_valid_i, tick_en} = 6'h0;
		{wb_adr_i, wb_dat_i, wb_sel_i, src_data_i} = '0;
		{num_errors, num_checks, ticks} = '0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		tick_en <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_modes();
		t_phase(5'h05);
		t_phase(5'h1f);
		t_phase(5'h00);
		t_ilas(4'hf);
		t_ilas(4'h0);
		stop_test();
	end
endmodule // jlc_link_ctrl_test
